// *** fsq_pkg.sv ***
// Shared constants, types and decode helpers of the flash sequencer
package fsq_pkg;

	// System clock rate and settle times
	localparam int unsigned CLK_MHZ = 125;
	localparam int unsigned VERIFY_SETTLE_NS = 4000; // Verify voltage settle
	localparam int unsigned DUMMY_SETTLE_NS = 2000; // After dummy write
	localparam int unsigned VPPE_SETTLE_NS = 5000; // After supply enable
	localparam int unsigned TMR_W = 10;

	// Least times, rounded up to whole cycles
	localparam logic [TMR_W-1:0] VERIFY_SETTLE_CYC =
		TMR_W'((VERIFY_SETTLE_NS * CLK_MHZ + 999) / 1000);
	localparam logic [TMR_W-1:0] DUMMY_SETTLE_CYC =
		TMR_W'((DUMMY_SETTLE_NS * CLK_MHZ + 999) / 1000);
	localparam logic [TMR_W-1:0] VPPE_SETTLE_CYC =
		TMR_W'((VPPE_SETTLE_NS * CLK_MHZ + 999) / 1000);

	// Register indices; byte address is four times the index
	localparam logic [23:0] IDX_MODE_CTRL = 24'hffff40;
	localparam logic [23:0] IDX_BLK_LO = 24'hffff42;
	localparam logic [23:0] IDX_BLK_HI = 24'hffff43;
	localparam logic [23:0] IDX_EV_STATUS = 24'hffff44;
	localparam logic [23:0] IDX_EV_CLEAR = 24'hffff45;
	localparam logic [23:0] IDX_EV_ENABLE = 24'hffff46;
	localparam logic [23:0] IDX_STATE = 24'hffff47;

	// Mode control bit positions
	localparam int unsigned MC_PROGRAM = 0;
	localparam int unsigned MC_ERASE = 1;
	localparam int unsigned MC_PV = 2;
	localparam int unsigned MC_EV = 3;
	localparam int unsigned MC_VPPE = 6;
	localparam logic [7:0] MC_WMASK = 8'h4f;
	localparam logic [7:0] REG_RESET = 8'h00;

	// Programmable flash range
	localparam logic [31:0] FLASH_TOP = 32'h0001ffff;
	localparam int unsigned FA_W = 17;

	// Event bits of the sticky status register
	localparam int unsigned EV_LATCH = 0; // Address and data latched
	localparam int unsigned EV_ILLEGAL = 1; // Illegal mode: conflicting control bits or an operation bit without supply enabled
	localparam int unsigned EV_RANGE = 2; // Access outside flash range
	localparam int unsigned EV_BLOCKED = 3; // Read during program/erase or illegal mode
	localparam int unsigned EV_EARLY = 4; // Verify read before settle
	localparam int unsigned NUM_EV = 5;

	// Operating modes of the array
	typedef enum logic [2:0] {
		MODE_NORMAL,
		MODE_PROGRAM,
		MODE_ERASE,
		MODE_PV,
		MODE_EV,
		MODE_PWV,
		MODE_ILLEGAL
	} fsq_mode_t;

	// Flash access request from the CPU side
	typedef struct packed {
		logic valid;
		logic write;
		logic [31:0] addr;
		logic [7:0] wdata;
	} fsq_flash_req_t;

	// Answer to a flash access
	typedef struct packed {
		logic ack;
		logic err;
		logic [7:0] rdata;
	} fsq_flash_rsp_t;

	// Controls toward the cell array
	typedef struct packed {
		fsq_mode_t op;
		logic [FA_W-1:0] addr;
		logic [7:0] data;
		logic [15:0] blocks;
	} fsq_cell_ctl_t;

	// Register select on an aligned word
	function automatic logic reg_hit(input logic [31:0] a,
		input logic [23:0] idx);
		return (a[31:26] == 6'h00) && (a[25:2] == idx) && (a[1:0] == 2'h0);
	endfunction

	// One operation at most, each needing the supply enabled
	function automatic fsq_mode_t decode_mode(input logic [7:0] ctrl,
		input logic supply);
		fsq_mode_t m;
		m = MODE_ILLEGAL;
		if (!(supply && ctrl[MC_VPPE]))
			m = (ctrl[3:0] == 4'h0) ? MODE_NORMAL : MODE_ILLEGAL;
		else
		begin
			unique case (ctrl[3:0])
				4'h0: m = MODE_PWV;
				4'h1: m = MODE_PROGRAM;
				4'h2: m = MODE_ERASE;
				4'h4: m = MODE_PV;
				4'h8: m = MODE_EV;
				default: m = MODE_ILLEGAL;
			endcase
		end
		return m;
	endfunction

endpackage

// *** fsq_irq.sv ***
// Sticky event status, enable mask and interrupt level
`timescale 1ns/1ps
module fsq_irq (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [fsq_pkg::NUM_EV-1:0] event_set,
	input wire logic clr_we,
	input wire logic en_we,
	input wire logic [fsq_pkg::NUM_EV-1:0] wdata,
	output logic [fsq_pkg::NUM_EV-1:0] status,
	output logic [fsq_pkg::NUM_EV-1:0] enable,
	output logic irq
);
	logic [fsq_pkg::NUM_EV-1:0] next_status; // Sticky bits
	logic [fsq_pkg::NUM_EV-1:0] next_enable; // Mask
	logic next_irq; // Level out

	// Set wins over a clear in the same cycle
	always_comb
	begin
		next_status = status & ~(clr_we ? wdata : '0);
		next_status = next_status | event_set;
		next_enable = en_we ? wdata : enable;
		next_irq = |(next_status & next_enable);
	end

	// State registers
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			status <= '0;
			enable <= '0;
			irq <= 1'b0;
		end
		else
		begin
			status <= next_status;
			enable <= next_enable;
			irq <= next_irq;
		end
	end
endmodule

// *** fsq_settle_timer.sv ***
// Down counter that marks when array voltages have settled
`timescale 1ns/1ps
module fsq_settle_timer (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic start,
	input wire logic [fsq_pkg::TMR_W-1:0] load,
	output logic done
);
	logic [fsq_pkg::TMR_W-1:0] count; // Cycles left
	logic [fsq_pkg::TMR_W-1:0] next_count;

	// Latest start restarts the wait
	always_comb
	begin
		next_count = count;
		if (start)
			next_count = load;
		else if (count != '0)
			next_count = count - 1'b1;
	end

	// Counter register
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			count <= '0;
		else
			count <= next_count;
	end

	assign done = (count == '0);
endmodule

// *** fsq_flash_seq.sv ***
// Flash program/erase sequencer with APB registers and array control
// Notes on behaviour
// - Program-verify reads return latched address data
// - Accepted flash range is 0 to 1ffff
// - Erase lasts while erase bit set
// - Dummy write latches erase-verify address
// - Enabled writes latch address and data
// - Four bits pick mode; none is prewrite-verify with supply enabled, else normal
// - No valid reads during program or erase
`timescale 1ns/1ps
module fsq_flash_seq (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic programming_supply,
	input wire fsq_pkg::fsq_flash_req_t flash_req,
	output fsq_pkg::fsq_flash_rsp_t flash_rsp,
	output fsq_pkg::fsq_cell_ctl_t cell_ctl,
	input wire logic [7:0] cell_rdata,
	output logic irq
);
	// Flash port states
	typedef enum logic {FP_IDLE, FP_READ} fsq_fp_state_t;

	logic [7:0] flash_mode_control; // Mode and supply enable bits
	logic [7:0] erase_block_select_lo; // Blocks 7..0
	logic [7:0] erase_block_select_hi; // Blocks 15..8
	logic [7:0] next_mode_control;
	logic [7:0] next_blk_lo;
	logic [7:0] next_blk_hi;
	logic [31:0] next_prdata;
	logic next_pslverr;
	logic wr_acc; // Write in access phase
	logic mapped; // Address hits a register
	logic clr_we; // Clear register written
	logic en_we; // Enable register written
	logic [31:0] rd_mux; // Read value

	fsq_pkg::fsq_mode_t mode; // Decoded mode
	fsq_pkg::fsq_mode_t prev_mode; // Mode one cycle back
	logic prev_vppe;
	logic vppe_on; // Supply enabled and present
	logic verify_mode; // Any verify mode
	fsq_fp_state_t fp_state;
	fsq_fp_state_t next_fp_state;
	logic [fsq_pkg::FA_W-1:0] latch_addr; // Address latch
	logic [7:0] latch_data; // Data latch
	logic [fsq_pkg::FA_W-1:0] next_latch_addr;
	logic [7:0] next_latch_data;
	fsq_pkg::fsq_flash_rsp_t next_rsp;
	fsq_pkg::fsq_cell_ctl_t next_cell;
	logic take; // Flash request taken this cycle
	logic in_range;
	logic tmr_start;
	logic [fsq_pkg::TMR_W-1:0] tmr_load;
	logic settled; // Settle wait elapsed
	logic [fsq_pkg::NUM_EV-1:0] events;
	logic [fsq_pkg::NUM_EV-1:0] ev_status;
	logic [fsq_pkg::NUM_EV-1:0] ev_enable;

	// Slave never inserts wait states
	assign pready = 1'b1;
	assign wr_acc = psel && penable && pwrite;

	// Address decode and read data
	always_comb
	begin
		mapped = 1'b1;
		rd_mux = 32'h0000_0000;
		if (fsq_pkg::reg_hit(paddr, fsq_pkg::IDX_MODE_CTRL))
			rd_mux = {24'h00_0000, flash_mode_control};
		else if (fsq_pkg::reg_hit(paddr, fsq_pkg::IDX_BLK_LO))
			rd_mux = {24'h00_0000, erase_block_select_lo};
		else if (fsq_pkg::reg_hit(paddr, fsq_pkg::IDX_BLK_HI))
			rd_mux = {24'h00_0000, erase_block_select_hi};
		else if (fsq_pkg::reg_hit(paddr, fsq_pkg::IDX_EV_STATUS))
			rd_mux = {27'h000_0000, ev_status};
		else if (fsq_pkg::reg_hit(paddr, fsq_pkg::IDX_EV_ENABLE))
			rd_mux = {27'h000_0000, ev_enable};
		else if (fsq_pkg::reg_hit(paddr, fsq_pkg::IDX_STATE))
			rd_mux = {27'h000_0000, mode, programming_supply, settled};
		else if (!fsq_pkg::reg_hit(paddr, fsq_pkg::IDX_EV_CLEAR))
			mapped = 1'b0;
	end

	// Register writes take effect at the access edge
	always_comb
	begin
		next_mode_control = flash_mode_control;
		next_blk_lo = erase_block_select_lo;
		next_blk_hi = erase_block_select_hi;
		next_prdata = prdata;
		next_pslverr = pslverr;
		clr_we = wr_acc && fsq_pkg::reg_hit(paddr, fsq_pkg::IDX_EV_CLEAR);
		en_we = wr_acc && fsq_pkg::reg_hit(paddr, fsq_pkg::IDX_EV_ENABLE);
		// Erase and verify bits act as soon as written
		if (wr_acc && fsq_pkg::reg_hit(paddr, fsq_pkg::IDX_MODE_CTRL))
			next_mode_control = pwdata[7:0] & fsq_pkg::MC_WMASK;
		if (wr_acc && fsq_pkg::reg_hit(paddr, fsq_pkg::IDX_BLK_LO))
			next_blk_lo = pwdata[7:0];
		if (wr_acc && fsq_pkg::reg_hit(paddr, fsq_pkg::IDX_BLK_HI))
			next_blk_hi = pwdata[7:0];
		// Answer prepared in the setup cycle
		if (psel && !penable)
		begin
			next_prdata = pwrite ? 32'h0000_0000 : rd_mux;
			next_pslverr = !mapped;
		end
	end

	// Register file
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			flash_mode_control <= fsq_pkg::REG_RESET;
			erase_block_select_lo <= fsq_pkg::REG_RESET;
			erase_block_select_hi <= fsq_pkg::REG_RESET;
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end
		else
		begin
			flash_mode_control <= next_mode_control;
			erase_block_select_lo <= next_blk_lo;
			erase_block_select_hi <= next_blk_hi;
			prdata <= next_prdata;
			pslverr <= next_pslverr;
		end
	end

	// Mode decode from the four control bits
	always_comb
	begin
		mode = fsq_pkg::decode_mode(flash_mode_control,
			programming_supply);
		vppe_on = flash_mode_control[fsq_pkg::MC_VPPE] && programming_supply;
		verify_mode = (mode == fsq_pkg::MODE_PV) ||
			(mode == fsq_pkg::MODE_EV) || (mode == fsq_pkg::MODE_PWV);
		take = (fp_state == FP_IDLE) && flash_req.valid && !flash_rsp.ack;
		in_range = (flash_req.addr <= fsq_pkg::FLASH_TOP);
	end

	// Flash port, latches, array control and events
	always_comb
	begin
		next_fp_state = fp_state;
		next_latch_addr = latch_addr;
		next_latch_data = latch_data;
		next_rsp = flash_rsp;
		next_rsp.ack = 1'b0;
		events = '0;
		tmr_start = 1'b0;
		tmr_load = fsq_pkg::VERIFY_SETTLE_CYC;
		// Erase pulse follows the erase bit
		next_cell.op = mode;
		next_cell.blocks = {erase_block_select_hi, erase_block_select_lo};
		next_cell.data = latch_data;
		// Verify modes look at the latched address
		next_cell.addr = (mode == fsq_pkg::MODE_NORMAL) ?
			cell_ctl.addr : latch_addr;
		// Entry to a verify mode starts the settle wait
		if (mode != prev_mode && verify_mode)
			tmr_start = 1'b1;
		if (mode == fsq_pkg::MODE_ILLEGAL && prev_mode != mode)
			events[fsq_pkg::EV_ILLEGAL] = 1'b1;
		// Supply enable rising starts its own wait
		if (flash_mode_control[fsq_pkg::MC_VPPE] && !prev_vppe)
		begin
			tmr_start = 1'b1;
			tmr_load = fsq_pkg::VPPE_SETTLE_CYC;
		end
		unique case (fp_state)
			FP_IDLE:
			begin
				if (take && flash_req.write)
				begin
					next_rsp.ack = 1'b1;
					next_rsp.err = 1'b1;
					next_rsp.rdata = 8'h00;
					if (!in_range)
						events[fsq_pkg::EV_RANGE] = 1'b1;
					else if (vppe_on)
					begin
						// Latch address and data
						next_latch_addr = flash_req.addr[fsq_pkg::FA_W-1:0];
						next_latch_data = flash_req.wdata;
						next_rsp.err = 1'b0;
						events[fsq_pkg::EV_LATCH] = 1'b1;
						// Dummy write restarts the settle wait
						if (mode == fsq_pkg::MODE_EV)
						begin
							tmr_start = 1'b1;
							tmr_load = fsq_pkg::DUMMY_SETTLE_CYC;
						end
					end
				end
				else if (take)
				begin
					if (mode == fsq_pkg::MODE_PROGRAM ||
						mode == fsq_pkg::MODE_ERASE ||
						mode == fsq_pkg::MODE_ILLEGAL || !in_range)
					begin
						// Array busy, mode illegal or address outside: refuse
						next_rsp.ack = 1'b1;
						next_rsp.err = 1'b1;
						next_rsp.rdata = 8'h00;
						events[fsq_pkg::EV_BLOCKED] = in_range;
						events[fsq_pkg::EV_RANGE] = !in_range;
					end
					else
					begin
						if (mode == fsq_pkg::MODE_NORMAL)
							next_cell.addr = flash_req.addr[fsq_pkg::FA_W-1:0];
						if (verify_mode && !settled)
							events[fsq_pkg::EV_EARLY] = 1'b1;
						next_fp_state = FP_READ;
					end
				end
			end
			FP_READ:
			begin
				// Array data for the address driven last cycle
				next_rsp.ack = 1'b1;
				next_rsp.err = 1'b0;
				next_rsp.rdata = cell_rdata;
				next_fp_state = FP_IDLE;
			end
		endcase
	end

	// Flash port registers
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			fp_state <= FP_IDLE;
			latch_addr <= '0;
			latch_data <= 8'h00;
			flash_rsp <= '0;
			cell_ctl <= '0;
			prev_mode <= fsq_pkg::MODE_NORMAL;
			prev_vppe <= 1'b0;
		end
		else
		begin
			fp_state <= next_fp_state;
			latch_addr <= next_latch_addr;
			latch_data <= next_latch_data;
			flash_rsp <= next_rsp;
			cell_ctl <= next_cell;
			prev_mode <= mode;
			prev_vppe <= flash_mode_control[fsq_pkg::MC_VPPE];
		end
	end

	// Settle wait for verify and supply enable
	fsq_settle_timer u_timer (
		.pclk(pclk),
		.presetn(presetn),
		.start(tmr_start),
		.load(tmr_load),
		.done(settled)
	);

	// Event status and interrupt
	fsq_irq u_irq (
		.pclk(pclk),
		.presetn(presetn),
		.event_set(events),
		.clr_we(clr_we),
		.en_we(en_we),
		.wdata(pwdata[fsq_pkg::NUM_EV-1:0]),
		.status(ev_status),
		.enable(ev_enable),
		.irq(irq)
	);

	// Verify read drives the latched address to the array
	a_pv_read_addr: assert property (@(posedge pclk) disable iff (!presetn)
		(take && !flash_req.write && in_range && mode == fsq_pkg::MODE_PV)
		|=> (cell_ctl.addr == latch_addr) ##1 flash_rsp.ack)
		else $error("verify read not at latched address");

	// Out-of-range write refused and latch untouched
	a_range_refuse: assert property (@(posedge pclk) disable iff (!presetn)
		(take && flash_req.write && !in_range)
		|=> flash_rsp.ack && flash_rsp.err && $stable(latch_addr))
		else $error("out-of-range write accepted");

	// Erase op on the array tracks the decoded mode
	a_erase_span: assert property (@(posedge pclk) disable iff (!presetn)
		1'b1 |=> ((cell_ctl.op == fsq_pkg::MODE_ERASE) ==
		($past(flash_mode_control) == 8'h42 && $past(programming_supply))))
		else $error("erase pulse not tied to erase bit");

	// Dummy write holds settled low for the next 8 cycles
	a_dummy_settle: assert property (@(posedge pclk) disable iff (!presetn)
		(take && flash_req.write && in_range && vppe_on &&
		mode == fsq_pkg::MODE_EV) |=> !settled [*8])
		else $error("dummy write did not restart settle wait");

	// Enabled write lands in both latches
	a_write_latch: assert property (@(posedge pclk) disable iff (!presetn)
		(take && flash_req.write && in_range && vppe_on)
		|=> latch_addr == $past(flash_req.addr[fsq_pkg::FA_W-1:0]) &&
		latch_data == $past(flash_req.wdata))
		else $error("write not latched");

	// Supply on with no mode bit gives prewrite-verify
	a_prewrite_mode: assert property (@(posedge pclk) disable iff (!presetn)
		(programming_supply && flash_mode_control[fsq_pkg::MC_VPPE] &&
		flash_mode_control[3:0] == 4'h0) |-> mode == fsq_pkg::MODE_PWV)
		else $error("prewrite-verify not selected");

	// Reads refused while the array is busy
	a_busy_read: assert property (@(posedge pclk) disable iff (!presetn)
		(take && !flash_req.write && in_range &&
		(mode == fsq_pkg::MODE_PROGRAM || mode == fsq_pkg::MODE_ERASE))
		|=> flash_rsp.ack && flash_rsp.err && flash_rsp.rdata == 8'h00)
		else $error("read served during program or erase");

	// Single operation with supply enabled
	a_one_op: assert property (@(posedge pclk) disable iff (!presetn)
		(mode inside {fsq_pkg::MODE_PROGRAM, fsq_pkg::MODE_ERASE,
		fsq_pkg::MODE_PV, fsq_pkg::MODE_EV})
		|-> vppe_on && $onehot(flash_mode_control[3:0]))
		else $error("operation without supply or not alone");
endmodule

// *** tb.sv ***
// Self-checking bench for the flash sequencer over APB and the flash port
`timescale 1ns/1ps
module tb;
	logic pclk; // System clock
	logic presetn; // Async reset, low active
	logic psel; // APB select
	logic penable; // APB access phase
	logic pwrite; // APB direction
	logic [31:0] paddr; // APB byte address
	logic [31:0] pwdata; // APB write data
	logic [31:0] prdata; // APB read data
	logic pready; // APB ready
	logic pslverr; // APB error
	logic programming_supply; // Supply present
	fsq_pkg::fsq_flash_req_t flash_req; // CPU flash request
	fsq_pkg::fsq_flash_rsp_t flash_rsp; // Flash answer
	fsq_pkg::fsq_cell_ctl_t cell_ctl; // Array controls
	logic [7:0] cell_rdata; // Array read data
	logic irq; // Interrupt level
	int failures; // Mismatch count
	int num_checks; // Comparison count
	int cyc; // Cycle count for the hang limit
	logic [31:0] rd; // Last read word
	logic er; // Last APB error
	fsq_pkg::fsq_flash_rsp_t rs; // Last flash answer
	int tries; // Program attempts made
	int pulse; // Program pulse length in cycles
	logic [7:0] codes [7]; // Mode control values
	fsq_pkg::fsq_mode_t modes [7]; // Expected array op

	fsq_flash_seq u_dut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr),
		.programming_supply(programming_supply), .flash_req(flash_req),
		.flash_rsp(flash_rsp), .cell_ctl(cell_ctl), .cell_rdata(cell_rdata),
		.irq(irq)
	);

	// Array model: data depends on the addressed cell
	assign cell_rdata = cell_ctl.addr[7:0] ^ 8'h5a;

	// Clock generator
	initial
	begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end

	// Hang limit
	initial
	begin
		cyc = 0;
		forever
		begin
			@(posedge pclk);
			cyc++;
			if (cyc == 20000)
			begin
				failures++;
				complete_run();
			end
		end
	end

	// Verdict and end of run
	task automatic complete_run;
		if (failures == 0 && num_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// Compare one value
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
			failures++;
		end
	endtask

	// One APB transfer, held until pready is seen
	task automatic apb(input logic w, input logic [23:0] idx,
		input logic [7:0] d, output logic [31:0] r, output logic e);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {6'h00, idx, 2'h0};
		pwdata <= {24'h000000, d};
		@(posedge pclk);
		penable <= 1'b1;
		// Ends when pready is seen, else at the hang limit
		do
		begin
			@(posedge pclk);
		end
		while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// One flash byte access, held until ack is seen
	task automatic fl(input logic w, input logic [31:0] a,
		input logic [7:0] d, output fsq_pkg::fsq_flash_rsp_t r);
		@(posedge pclk);
		flash_req <= '{valid: 1'b1, write: w, addr: a, wdata: d};
		// Ends when ack is seen, else at the hang limit
		do
		begin
			@(posedge pclk);
		end
		while (flash_rsp.ack !== 1'b1);
		r = flash_rsp;
		flash_req.valid <= 1'b0;
	endtask

	// Write mode control and let the array op follow
	task automatic set_mode(input logic [7:0] c);
		apb(1'b1, fsq_pkg::IDX_MODE_CTRL, c, rd, er);
		repeat (3) @(posedge pclk);
	endtask

	// Main sequence
	initial
	begin
		failures = 0;
		num_checks = 0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = '0;
		programming_supply = 1'b1;
		flash_req = '0;
		codes = '{8'h40, 8'h41, 8'h42, 8'h44, 8'h48, 8'h43, 8'h00};
		modes = '{fsq_pkg::MODE_PWV, fsq_pkg::MODE_PROGRAM,
			fsq_pkg::MODE_ERASE, fsq_pkg::MODE_PV, fsq_pkg::MODE_EV,
			fsq_pkg::MODE_ILLEGAL, fsq_pkg::MODE_NORMAL};
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		// Reset values
		apb(1'b0, fsq_pkg::IDX_MODE_CTRL, 8'h00, rd, er);
		chk(rd, 32'h0);
		apb(1'b0, fsq_pkg::IDX_BLK_LO, 8'h00, rd, er);
		chk(rd, 32'h0);
		apb(1'b0, fsq_pkg::IDX_BLK_HI, 8'h00, rd, er);
		chk(rd, 32'h0);
		// Block selects read back
		apb(1'b1, fsq_pkg::IDX_BLK_LO, 8'ha5, rd, er);
		apb(1'b1, fsq_pkg::IDX_BLK_HI, 8'h3c, rd, er);
		apb(1'b0, fsq_pkg::IDX_BLK_LO, 8'h00, rd, er);
		chk(rd, 32'ha5);
		apb(1'b0, fsq_pkg::IDX_BLK_HI, 8'h00, rd, er);
		chk(rd, 32'h3c);
		// Unmapped word gives an error
		apb(1'b0, 24'hffff41, 8'h00, rd, er);
		chk({31'h0, er}, 32'h1);
		// Write mask and conflicting bits
		set_mode(8'hff);
		apb(1'b0, fsq_pkg::IDX_MODE_CTRL, 8'h00, rd, er);
		chk(rd, {24'h0, fsq_pkg::MC_WMASK});
		chk({29'h0, cell_ctl.op}, {29'h0, fsq_pkg::MODE_ILLEGAL});
		apb(1'b0, fsq_pkg::IDX_EV_STATUS, 8'h00, rd, er);
		chk({31'h0, rd[fsq_pkg::EV_ILLEGAL]}, 32'h1);
		// Every mode code
		for (int i = 0; i < 7; i++)
		begin
			set_mode(codes[i]);
			chk({29'h0, cell_ctl.op}, {29'h0, modes[i]});
		end
		// No supply present
		programming_supply <= 1'b0;
		set_mode(8'h41);
		chk({29'h0, cell_ctl.op}, {29'h0, fsq_pkg::MODE_ILLEGAL});
		set_mode(8'h40);
		chk({29'h0, cell_ctl.op}, {29'h0, fsq_pkg::MODE_NORMAL});
		fl(1'b1, 32'h00000010, 8'h11, rs);
		chk({31'h0, rs.err}, 32'h1);
		programming_supply <= 1'b1;
		// Latch at the top of the range, refuse past it
		set_mode(8'h40);
		fl(1'b1, 32'h0001ffff, 8'h33, rs);
		chk({31'h0, rs.err}, 32'h0);
		fl(1'b1, 32'h00020000, 8'h44, rs);
		chk({31'h0, rs.err}, 32'h1);
		// Program-verify reads the latched cell
		set_mode(8'h44);
		chk({15'h0, cell_ctl.addr}, 32'h1ffff);
		chk({24'h0, cell_ctl.data}, 32'h33);
		repeat (520) @(posedge pclk);
		fl(1'b0, 32'h0001ffff, 8'h00, rs);
		chk({31'h0, rs.err}, 32'h0);
		chk({24'h0, rs.rdata}, 32'ha5);
		// Reads refused while programming
		set_mode(8'h41);
		fl(1'b0, 32'h00000010, 8'h00, rs);
		chk({23'h0, rs.err, rs.rdata}, 32'h100);
		apb(1'b0, fsq_pkg::IDX_EV_STATUS, 8'h00, rd, er);
		chk({31'h0, rd[fsq_pkg::EV_BLOCKED]}, 32'h1);
		// Erase lasts while its bit is set
		set_mode(8'h42);
		chk({29'h0, cell_ctl.op}, {29'h0, fsq_pkg::MODE_ERASE});
		set_mode(8'h40);
		chk({29'h0, cell_ctl.op}, {29'h0, fsq_pkg::MODE_PWV});
		// Dummy write latches the erase-verify address
		set_mode(8'h48);
		fl(1'b1, 32'h00000123, 8'hff, rs);
		repeat (2) @(posedge pclk);
		chk({15'h0, cell_ctl.addr}, 32'h123);
		repeat (270) @(posedge pclk);
		fl(1'b0, 32'h00000123, 8'h00, rs);
		chk({23'h0, rs.err, rs.rdata}, 32'h79);
		// Interrupt: masked, enabled, cleared
		apb(1'b1, fsq_pkg::IDX_EV_CLEAR, 8'h1f, rd, er);
		fl(1'b1, 32'h00030000, 8'h00, rs);
		repeat (2) @(posedge pclk);
		chk({31'h0, irq}, 32'h0);
		apb(1'b0, fsq_pkg::IDX_EV_STATUS, 8'h00, rd, er);
		chk(rd, 32'h4);
		apb(1'b1, fsq_pkg::IDX_EV_ENABLE, 8'h04, rd, er);
		repeat (2) @(posedge pclk);
		chk({31'h0, irq}, 32'h1);
		apb(1'b1, fsq_pkg::IDX_EV_CLEAR, 8'h04, rd, er);
		repeat (2) @(posedge pclk);
		chk({31'h0, irq}, 32'h0);
		apb(1'b0, fsq_pkg::IDX_EV_STATUS, 8'h00, rd, er);
		chk(rd, 32'h0);
		// Program one byte, doubling the pulse until tries run out
		set_mode(8'h40);
		repeat (700) @(posedge pclk);
		apb(1'b1, fsq_pkg::IDX_BLK_LO, 8'h01, rd, er);
		fl(1'b1, 32'h00000010, 8'h33, rs);
		chk({31'h0, rs.err}, 32'h0);
		pulse = 4;
		tries = 0;
		do
		begin
			set_mode(8'h41);
			repeat (pulse) @(posedge pclk);
			set_mode(8'h44);
			repeat (520) @(posedge pclk);
			fl(1'b0, 32'h00000010, 8'h00, rs);
			chk({23'h0, rs.err, rs.rdata}, 32'h4a);
			pulse = pulse * 2;
			tries++;
		end
		while (rs.rdata != 8'h33 && tries < 6);
		chk(tries, 32'h6);
		apb(1'b0, fsq_pkg::IDX_EV_STATUS, 8'h00, rd, er);
		chk({31'h0, rd[fsq_pkg::EV_EARLY]}, 32'h0);
		// Retries exhausted: tidy up in order
		set_mode(8'h40);
		apb(1'b1, fsq_pkg::IDX_BLK_LO, 8'h00, rd, er);
		set_mode(8'h00);
		apb(1'b0, fsq_pkg::IDX_MODE_CTRL, 8'h00, rd, er);
		chk(rd, 32'h0);
		// Prewrite, erase and erase-verify of one block
		set_mode(8'h40);
		repeat (700) @(posedge pclk);
		fl(1'b1, 32'h000000a5, 8'h00, rs);
		set_mode(8'h41);
		set_mode(8'h40);
		chk({24'h0, cell_ctl.data}, 32'h0);
		apb(1'b1, fsq_pkg::IDX_BLK_LO, 8'h01, rd, er);
		apb(1'b1, fsq_pkg::IDX_BLK_HI, 8'h00, rd, er);
		set_mode(8'h42);
		chk({16'h0, cell_ctl.blocks}, 32'h1);
		repeat (20) @(posedge pclk);
		chk({29'h0, cell_ctl.op}, {29'h0, fsq_pkg::MODE_ERASE});
		set_mode(8'h48);
		chk({29'h0, cell_ctl.op}, {29'h0, fsq_pkg::MODE_EV});
		repeat (520) @(posedge pclk);
		fl(1'b1, 32'h000000a5, 8'hff, rs);
		chk({31'h0, rs.err}, 32'h0);
		repeat (260) @(posedge pclk);
		fl(1'b0, 32'h000000a5, 8'h00, rs);
		chk({23'h0, rs.err, rs.rdata}, 32'hff);
		set_mode(8'h40);
		apb(1'b1, fsq_pkg::IDX_BLK_LO, 8'h00, rd, er);
		set_mode(8'h00);
		chk({29'h0, cell_ctl.op}, {29'h0, fsq_pkg::MODE_NORMAL});
		// Verify read before the settle wait is flagged
		apb(1'b1, fsq_pkg::IDX_EV_CLEAR, 8'h1f, rd, er);
		set_mode(8'h44);
		fl(1'b0, 32'h00000010, 8'h00, rs);
		apb(1'b0, fsq_pkg::IDX_EV_STATUS, 8'h00, rd, er);
		chk(rd, 32'h10);
		set_mode(8'h00);
		complete_run();
	end
endmodule
